// ===== rtl/nvx_pkg.sv
package nvx_pkg;

    ////////////////////////////////////////////////////////////////////
    localparam logic [7:0] USER_LAST  = 8'h3F;
    localparam logic [7:0] RSV_FIRST  = 8'h40;
    localparam logic [7:0] RSV_LAST   = 8'hE7;
    localparam logic [7:0] NVR_LAST   = 8'hEF;
    localparam logic [7:0] OFS_PU_LO  = 8'hF0;
    localparam logic [7:0] OFS_PU_HI  = 8'hF1;
    localparam logic [7:0] OFS_DR_LO  = 8'hF2;
    localparam logic [7:0] OFS_DR_HI  = 8'hF3;
    localparam logic [7:0] OFS_CFG    = 8'hF4;
    localparam logic [7:0] XNV_FIRST  = 8'hF5;
    localparam logic [7:0] XNV_LAST   = 8'hF7;
    localparam logic [7:0] OFS_LVL_LO = 8'hF8;
    localparam logic [7:0] OFS_LVL_HI = 8'hF9;
    localparam logic [7:0] SRAM_FIRST = 8'hFA;

    localparam logic [7:0] RST_MEM    = 8'h00;
    localparam logic [7:0] RST_PU_LO  = 8'h00;
    localparam logic       RST_PU_HI  = 1'b0;
    localparam logic [7:0] RST_DR_LO  = 8'hFF;
    localparam logic       RST_DR_HI  = 1'b1;
    localparam logic       RST_SEE    = 1'b0;
    localparam logic [3:0] SLV_ID     = 4'hA;
    localparam logic [3:0] BIT_LAST   = 4'h7;
    localparam logic [3:0] BIT_ACK    = 4'h8;

    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WR_US       = 10;
    localparam int BUSY_W        = 12;
    localparam logic [BUSY_W-1:0] WR_CYCLES =
        BUSY_W'((T_WR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLV,
        ST_MEM,
        ST_WR,
        ST_RD,
        ST_IGN
    } nvx_phase_t;

    typedef struct packed {
        logic              scl_m;
        logic              scl_s;
        logic              scl_d;
        logic              sda_m;
        logic              sda_s;
        logic              sda_d;
        logic              tgl_m;
        logic              tgl_s;
        logic              tgl_d;
        logic [8:0]        io_m;
        logic [8:0]        io_s;
        logic [2:0]        asel_m;
        logic [2:0]        asel_s;
        nvx_phase_t        phase;
        logic [3:0]        cnt;
        logic [7:0]        sh;
        logic [7:0]        tx;
        logic [7:0]        ptr;
        logic              rw;
        logic              ack;
        logic              oe;
        logic              dirty;
        logic [BUSY_W-1:0] busy;
        logic [7:0]        pu_lo;
        logic              pu_hi;
        logic [7:0]        dr_lo;
        logic              dr_hi;
        logic              see;
        logic [63:0][7:0]  user;
        logic [2:0][7:0]   xnv;
        logic [5:0][7:0]   sram;
    } nvx_state_t;

endpackage

// ===== rtl/nvx_expander.sv
module nvx_expander
    import nvx_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       addr_sel_0,
    input  wire logic       addr_sel_1,
    input  wire logic       addr_sel_2,
    input  wire logic [8:0] io_in,
    output logic      [8:0] io_out,
    output logic      [8:0] io_oe,
    output logic      [8:0] io_pu_en
);

    ////////////////////////////////////////////////////////////////////
    // link domain: bit capture on the master's clock
    logic smp_bit;
    logic smp_tgl;

    always_ff @(posedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            smp_bit <= 1'b1;
            smp_tgl <= 1'b0;
        end
        else
        begin
            smp_bit <= sda_in;
            smp_tgl <= ~smp_tgl;
        end
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rd_byte(nvx_state_t s, logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            OFS_PU_LO:  d = s.pu_lo;
            OFS_PU_HI:  d = {7'h00, s.pu_hi};
            OFS_DR_LO:  d = s.dr_lo;
            OFS_DR_HI:  d = {7'h00, s.dr_hi};
            OFS_CFG:    d = {7'h00, s.see};
            OFS_LVL_LO: d = s.io_s[7:0];
            OFS_LVL_HI: d = {7'h00, s.io_s[8]};
            default:
            begin
                if (a <= USER_LAST)
                    d = s.user[a[5:0]];
                else if (a >= XNV_FIRST && a <= XNV_LAST)
                    d = s.xnv[2'(a - XNV_FIRST)];
                else if (a >= SRAM_FIRST)
                    d = s.sram[3'(a - SRAM_FIRST)];
                // reserved spaces read a steady zero
            end
        endcase
        return d;
    endfunction

    // shadowed bytes only cost a nonvolatile cycle while see is clear
    function automatic nvx_state_t mem_wr(nvx_state_t s, logic [7:0] a,
                                          logic [7:0] b);
        nvx_state_t n;
        n = s;
        unique case (a)
            OFS_PU_LO:  n.pu_lo = b;
            OFS_PU_HI:  n.pu_hi = b[0];
            OFS_DR_LO:  n.dr_lo = b;
            OFS_DR_HI:  n.dr_hi = b[0];
            OFS_CFG:    n.see = b[0];
            OFS_LVL_LO: n = s;
            OFS_LVL_HI: n = s;
            default:
            begin
                if (a <= USER_LAST)
                begin
                    n.user[a[5:0]] = b;
                    n.dirty = 1'b1;
                end
                else if (a >= XNV_FIRST && a <= XNV_LAST)
                begin
                    n.xnv[2'(a - XNV_FIRST)] = b;
                    n.dirty = 1'b1;
                end
                else if (a >= SRAM_FIRST)
                    n.sram[3'(a - SRAM_FIRST)] = b;
                // 40h-EFh: nothing changes
            end
        endcase
        if (a >= OFS_PU_LO && a <= OFS_CFG && !s.see)
            n.dirty = 1'b1;
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////
    nvx_state_t q;
    nvx_state_t next_q;
    logic       rise_ev;
    logic       fall_ev;
    logic       start_ev;
    logic       stop_ev;
    logic [7:0] rx_byte;
    logic [7:0] rd_now;
    logic       tx_bit;

    always_comb
    begin
        rise_ev  = q.tgl_s ^ q.tgl_d;
        fall_ev  = q.scl_d & ~q.scl_s;
        start_ev = q.scl_s & q.scl_d & q.sda_d & ~q.sda_s;
        stop_ev  = q.scl_s & q.scl_d & ~q.sda_d & q.sda_s;
        rx_byte  = {q.sh[6:0], smp_bit};
        rd_now   = rd_byte(q, q.ptr);
        tx_bit   = q.tx[3'(BIT_LAST - q.cnt)];
    end

    always_comb
    begin
        next_q = q;
        // smp_bit is only read once the toggle has crossed, so it is steady
        next_q.scl_m  = scl;
        next_q.scl_s  = q.scl_m;
        next_q.scl_d  = q.scl_s;
        next_q.sda_m  = sda_in;
        next_q.sda_s  = q.sda_m;
        next_q.sda_d  = q.sda_s;
        next_q.tgl_m  = smp_tgl;
        next_q.tgl_s  = q.tgl_m;
        next_q.tgl_d  = q.tgl_s;
        next_q.io_m   = io_in;
        next_q.io_s   = q.io_m;
        next_q.asel_m = {addr_sel_2, addr_sel_1, addr_sel_0};
        next_q.asel_s = q.asel_m;
        if (q.busy != '0)
            next_q.busy = q.busy - 1'b1;

        if (start_ev)
        begin
            next_q.phase = ST_SLV;
            next_q.cnt   = '0;
            next_q.oe    = 1'b0;
        end
        else if (stop_ev)
        begin
            next_q.phase = ST_IDLE;
            next_q.oe    = 1'b0;
            if (q.dirty)
            begin
                next_q.busy  = WR_CYCLES;
                next_q.dirty = 1'b0;
            end
        end
        else if (rise_ev)
        begin
            unique case (q.phase)
                ST_SLV, ST_MEM, ST_WR:
                begin
                    if (q.cnt != BIT_ACK)
                    begin
                        next_q.sh  = rx_byte;
                        next_q.cnt = q.cnt + 1'b1;
                        if (q.cnt == BIT_LAST)
                        begin
                            next_q.ack = 1'b1;
                            if (q.phase == ST_SLV)
                            begin
                                // top nibble fixed, pins on bits 3:1
                                next_q.ack = (rx_byte[7:1] ==
                                              {SLV_ID, q.asel_s})
                                             && (q.busy == '0);
                                next_q.rw  = rx_byte[0];
                            end
                            else if (q.phase == ST_MEM)
                                next_q.ptr = rx_byte;
                            else
                            begin
                                next_q     = mem_wr(next_q, q.ptr, rx_byte);
                                next_q.ack = 1'b1;
                                next_q.ptr = {q.ptr[7:3],
                                              q.ptr[2:0] + 3'h1};
                            end
                        end
                    end
                    else
                    begin
                        next_q.cnt = '0;
                        if (q.phase == ST_SLV && !q.ack)
                            next_q.phase = ST_IGN;
                        else if (q.phase == ST_SLV && q.rw)
                        begin
                            next_q.phase = ST_RD;
                            next_q.tx    = rd_now;
                            next_q.ptr   = q.ptr + 8'h01;
                        end
                        else if (q.phase == ST_SLV)
                            next_q.phase = ST_MEM;
                        else
                            next_q.phase = ST_WR;
                    end
                end
                ST_RD:
                begin
                    if (q.cnt != BIT_ACK)
                        next_q.cnt = q.cnt + 1'b1;
                    else if (!smp_bit)
                    begin
                        next_q.cnt = '0;
                        next_q.tx  = rd_now;
                        next_q.ptr = q.ptr + 8'h01;
                    end
                    else
                        next_q.phase = ST_IGN;
                end
                default:
                    next_q.phase = q.phase;
            endcase
        end
        else if (fall_ev)
        begin
            // pin changes only while the master holds the clock low
            unique case (q.phase)
                ST_SLV, ST_MEM, ST_WR:
                    next_q.oe = (q.cnt == BIT_ACK) && q.ack;
                ST_RD:
                    next_q.oe = (q.cnt != BIT_ACK) && !tx_bit;
                default:
                    next_q.oe = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q        <= '0;
            q.scl_m  <= 1'b1;
            q.scl_s  <= 1'b1;
            q.scl_d  <= 1'b1;
            q.sda_m  <= 1'b1;
            q.sda_s  <= 1'b1;
            q.sda_d  <= 1'b1;
            q.user   <= {64{RST_MEM}};
            q.xnv    <= {3{RST_MEM}};
            q.pu_lo  <= RST_PU_LO;
            q.pu_hi  <= RST_PU_HI;
            q.dr_lo  <= RST_DR_LO;
            q.dr_hi  <= RST_DR_HI;
            q.see    <= RST_SEE;
        end
        else
            q <= next_q;
    end

    ////////////////////////////////////////////////////////////////////
    // open drain: the pin is only ever pulled low
    assign sda_out  = 1'b0;
    assign sda_oe   = q.oe;
    assign io_out   = 9'h000;
    assign io_oe    = ~{q.dr_hi, q.dr_lo};
    assign io_pu_en = {q.pu_hi, q.pu_lo};

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    chk_tx_fall_edge: assert property (
        $rose(sda_oe) |-> $past(fall_ev)
    ) else $error("sda driven low outside a falling clock edge");

    chk_tx_bit_value: assert property (
        (q.phase == ST_RD && q.cnt != BIT_ACK && fall_ev && !start_ev
         && !stop_ev) |=> (sda_oe == !$past(tx_bit))
    ) else $error("transmitted bit does not match data byte");

    chk_addr_ack: assert property (
        (q.phase == ST_SLV && q.cnt == BIT_ACK && q.ack && fall_ev
         && !start_ev && !stop_ev) |=> sda_oe
    ) else $error("matching address not acknowledged");

    chk_busy_nack: assert property (
        (q.phase == ST_SLV && rise_ev && q.cnt == BIT_LAST && q.busy > 1
         && !start_ev && !stop_ev) |=> !q.ack
    ) else $error("address acknowledged during nonvolatile write");

    chk_stop_busy: assert property (
        (stop_ev && q.dirty && !start_ev) |=> (q.busy == WR_CYCLES)
    ) else $error("busy period not started after stop");

    chk_ignore_quiet: assert property (
        (q.phase == ST_IGN) |-> !sda_oe
    ) else $error("sda driven while ignoring the bus");

    chk_page_wrap: assert property (
        (q.phase == ST_WR && rise_ev && q.cnt == BIT_LAST && !start_ev
         && !stop_ev) |=> (q.ptr[7:3] == $past(q.ptr[7:3]))
         && (q.ptr[2:0] == $past(q.ptr[2:0]) + 3'h1)
    ) else $error("write pointer left its row");

    chk_msb_first: assert property (
        (q.phase == ST_MEM && rise_ev && q.cnt == BIT_LAST && !start_ev
         && !stop_ev) |=> (q.ptr == $past(rx_byte))
    ) else $error("memory address not assembled msb first");

    chk_read_start: assert property (
        (q.phase == ST_SLV && rise_ev && q.cnt == BIT_ACK && q.ack && q.rw
         && !start_ev && !stop_ev)
        |=> (q.phase == ST_RD) && (q.tx == $past(rd_now))
    ) else $error("read did not start at the address pointer");

    chk_nack_release: assert property (
        (q.phase == ST_RD && rise_ev && q.cnt == BIT_ACK && smp_bit
         && !start_ev && !stop_ev) |=> (q.phase == ST_IGN) ##1 !sda_oe [*2]
    ) else $error("sda not released after master nack");

    chk_rsv_nochange: assert property (
        (q.phase == ST_WR && rise_ev && q.cnt == BIT_LAST && !start_ev
         && !stop_ev && q.ptr >= RSV_FIRST && q.ptr <= NVR_LAST)
        |=> $stable(q.user) && $stable(q.xnv) && $stable(q.sram) && $stable(q.dirty)
    ) else $error("reserved write changed device state");

    chk_status_ro: assert property (
        (q.phase == ST_WR && rise_ev && q.cnt == BIT_LAST && !start_ev
         && !stop_ev && (q.ptr == OFS_LVL_LO || q.ptr == OFS_LVL_HI))
        |=> $stable(io_oe) && $stable(io_pu_en)
    ) else $error("status write changed pin control");

    chk_user_write: assert property (
        (q.phase == ST_WR && rise_ev && q.cnt == BIT_LAST && !start_ev
         && !stop_ev && q.ptr <= USER_LAST)
        |=> (q.user[$past(q.ptr[5:0])] == $past(rx_byte)) && q.dirty
    ) else $error("user byte not stored");

    chk_sram_volatile: assert property (
        (q.phase == ST_WR && rise_ev && q.cnt == BIT_LAST && !start_ev
         && !stop_ev && q.ptr >= SRAM_FIRST)
        |=> (q.sram[3'($past(q.ptr) - SRAM_FIRST)] == $past(rx_byte))
            && $stable(q.dirty)
    ) else $error("volatile byte not stored or marked nonvolatile");

    // the old see value decides, so the write to see itself still costs a cycle
    chk_shadow_only: assert property (
        (q.phase == ST_WR && rise_ev && q.cnt == BIT_LAST && !start_ev
         && !stop_ev && q.ptr >= OFS_PU_LO && q.ptr <= OFS_CFG)
        |=> (q.dirty == ($past(q.dirty) || !$past(q.see)))
    ) else $error("shadow-only bit ignored on a shadowed write");

    chk_start_addr: assert property (
        start_ev |=> (q.phase == ST_SLV) && (q.cnt == '0) && !sda_oe
    ) else $error("start did not begin an address byte");

    chk_read_next: assert property (
        (q.phase == ST_RD && rise_ev && q.cnt == BIT_ACK && !smp_bit
         && !start_ev && !stop_ev)
        |=> (q.tx == $past(rd_now)) && (q.ptr == $past(q.ptr) + 8'h01)
    ) else $error("read did not advance to the next byte");

    chk_data_ack: assert property (
        (q.phase == ST_WR && q.cnt == BIT_ACK && q.ack && fall_ev
         && !start_ev && !stop_ev) |=> sda_oe
    ) else $error("data byte not acknowledged");

    chk_ignore_hold: assert property (
        (q.phase == ST_IGN && !start_ev && !stop_ev) |=> (q.phase == ST_IGN)
    ) else $error("ignored transfer resumed without a start");

    chk_stop_idle: assert property (
        (stop_ev && !start_ev) |=> (q.phase == ST_IDLE) && !sda_oe
    ) else $error("stop did not release the bus");

endmodule // nvx_expander

// ===== verif/nvx_i2c_master.sv
module nvx_i2c_master (
    input  wire logic lclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    // phases of 8 link ticks keep well above the 4-cycle sync limit
    localparam int HALF = 8;

    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic ticks(input int n);
        repeat (n) @(posedge lclk);
        #1;
    endtask

    task automatic bit_put(input logic b);
        ticks(2);
        sda_low = !b;
        ticks(HALF);
        scl = 1'b1;
        ticks(HALF);
        scl = 1'b0;
    endtask

    task automatic bit_get(output logic b);
        ticks(2);
        sda_low = 1'b0;
        ticks(HALF);
        scl = 1'b1;
        ticks(HALF / 2);
        b = sda;
        ticks(HALF / 2);
        scl = 1'b0;
    endtask

    task automatic start();
        sda_low = 1'b0;
        ticks(HALF);
        scl = 1'b1;
        ticks(HALF);
        sda_low = 1'b1;
        ticks(HALF);
        scl = 1'b0;
    endtask

    task automatic stop();
        ticks(2);
        sda_low = 1'b1;
        ticks(HALF);
        scl = 1'b1;
        ticks(HALF);
        sda_low = 1'b0;
        ticks(HALF);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
        begin
            bit_put(d[i]);
        end
        bit_get(a);
        ack = !a;
    endtask

    // more=0 sends the closing not-acknowledge
    task automatic rd_byte(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
        begin
            bit_get(d[i]);
        end
        bit_put(!more);
    endtask
endmodule // nvx_i2c_master

// ===== verif/nvx_expander_tb.sv
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module nvx_expander_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
        logic [7:0] mask;
        logic       nv;
    } nvx_row_t;

    localparam logic [6:0] SLV = 7'b1010_101;

    logic       ref_clk;
    logic       lclk;
    logic       rstn;
    logic [8:0] io_in;
    logic [2:0] asel;
    logic       sda_out;
    logic       sda_oe;
    logic [8:0] io_out;
    logic [8:0] io_oe;
    logic [8:0] io_pu_en;
    logic       scl;
    logic       m_low;
    logic       sda;
    logic       ack;
    logic [7:0] b;
    logic [7:0] q[$];
    int         failures;
    int         num_checks;
    int         cyc;
    int         n;
    nvx_row_t   rows[16];

    // pulled-up wire: low while either party pulls
    assign sda = !(sda_oe | m_low);

    nvx_expander DUT (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .scl        (scl),
        .sda_in     (sda),
        .sda_out    (sda_out),
        .sda_oe     (sda_oe),
        .addr_sel_0 (asel[0]),
        .addr_sel_1 (asel[1]),
        .addr_sel_2 (asel[2]),
        .io_in      (io_in),
        .io_out     (io_out),
        .io_oe      (io_oe),
        .io_pu_en   (io_pu_en)
    );

    nvx_i2c_master u_mst (
        .lclk    (lclk),
        .sda     (sda),
        .scl     (scl),
        .sda_low (m_low)
    );

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = !ref_clk;
    end

    initial
    begin
        lclk = 1'b0;
        #3;
        forever #7.5 lclk = !lclk;
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        // about 60k cycles expected for the whole run
        if (cyc == 90000)
        begin
            failures++;
            complete_run();
        end
    end

    always @(sda_oe)
    begin
        if (rstn === 1'b1)
        begin
            `CHK("sda change in scl low", 1'b0, scl)
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr_seq(input logic [7:0] addr, input logic [7:0] d[$]);
        u_mst.start();
        u_mst.wr_byte({SLV, 1'b0}, ack);
        `CHK("slave address ack", 1'b1, ack)
        u_mst.wr_byte(addr, ack);
        `CHK("memory address ack", 1'b1, ack)
        foreach (d[i])
        begin
            u_mst.wr_byte(d[i], ack);
            `CHK("data ack", 1'b1, ack)
        end
        u_mst.stop();
    endtask

    // acknowledge polling, counts attempts until the address is taken
    task automatic poll(output int cnt);
        cnt = 0;
        do
        begin
            cnt++;
            u_mst.start();
            u_mst.wr_byte({SLV, 1'b0}, ack);
            u_mst.stop();
        end while (!ack && cnt < 40);
        `CHK("poll ack", 1'b1, ack)
    endtask

    task automatic rd_seq(input logic [7:0] addr, input int cnt);
        logic [7:0] d;
        q = {};
        u_mst.start();
        u_mst.wr_byte({SLV, 1'b0}, ack);
        u_mst.wr_byte(addr, ack);
        u_mst.start();
        u_mst.wr_byte({SLV, 1'b1}, ack);
        `CHK("read address ack", 1'b1, ack)
        for (int i = 0; i < cnt; i++)
        begin
            u_mst.rd_byte(i < cnt - 1, d);
            q.push_back(d);
        end
        repeat (8) @(posedge ref_clk);
        `CHK("released after nack", 1'b0, sda_oe)
        u_mst.stop();
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        io_in = 9'h1A5;
        asel = 3'b101;
        failures = 0;
        num_checks = 0;
        cyc = 0;
        rows = '{'{8'h00, 8'h5A, 8'h5A, 8'hFF, 1'b1}, '{8'h3F, 8'hA5, 8'hA5, 8'hFF, 1'b1},
                 '{8'h40, 8'h77, 8'h00, 8'hFF, 1'b0}, '{8'hE7, 8'h11, 8'h00, 8'hFF, 1'b0},
                 '{8'hE8, 8'h22, 8'h00, 8'hFF, 1'b0}, '{8'hF0, 8'h81, 8'h81, 8'hFF, 1'b1},
                 '{8'hF1, 8'hFF, 8'h01, 8'hFF, 1'b1}, '{8'hF5, 8'h3C, 8'h3C, 8'hFF, 1'b1},
                 '{8'hF7, 8'hC3, 8'hC3, 8'hFF, 1'b1}, '{8'hF4, 8'h01, 8'h01, 8'hFF, 1'b1},
                 '{8'hF2, 8'h0F, 8'h0F, 8'hFF, 1'b0}, '{8'hF3, 8'h00, 8'h00, 8'hFF, 1'b0},
                 '{8'hF8, 8'h00, 8'hA5, 8'hFF, 1'b0}, '{8'hF9, 8'h00, 8'h01, 8'h01, 1'b0},
                 '{8'hFA, 8'h99, 8'h99, 8'hFF, 1'b0}, '{8'hFF, 8'h66, 8'h66, 8'hFF, 1'b0}};
        repeat (20) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge ref_clk);
        foreach (rows[i])
        begin
            wr_seq(rows[i].addr, '{rows[i].wdata});
            poll(n);
            `CHK("write busy", rows[i].nv, n > 1)
            rd_seq(rows[i].addr, 1);
            `CHK("readback", rows[i].exp, q[0] & rows[i].mask)
        end
        `CHK("pullup pins", 9'h181, io_pu_en)
        `CHK("pulldown pins", 9'h1F0, io_oe)
        rd_seq(8'h3F, 2);
        `CHK("read across 3Fh", 16'hA500, {q[0], q[1]})
        // each strap setting: matching address acked, complemented address ignored
        for (int k = 0; k < 8; k++)
        begin
            @(posedge ref_clk);
            #1 asel = 3'(k);
            repeat (4) @(posedge ref_clk);
            u_mst.start();
            u_mst.wr_byte({4'b1010, 3'(k), 1'b0}, ack);
            `CHK("strap match", 1'b1, ack)
            u_mst.start();
            u_mst.wr_byte({4'b1010, ~3'(k), 1'b0}, ack);
            `CHK("strap mismatch", 1'b0, ack)
            u_mst.wr_byte(8'h00, ack);
            `CHK("ignored byte", 1'b0, ack)
            u_mst.stop();
        end
        @(posedge ref_clk);
        #1 asel = 3'b101;
        repeat (4) @(posedge ref_clk);
        wr_seq(8'h0E, '{8'h11, 8'h22, 8'h33, 8'h44});
        poll(n);
        rd_seq(8'h08, 1);
        `CHK("row wrap", 8'h33, q[0])
        u_mst.start();
        u_mst.wr_byte({SLV, 1'b1}, ack);
        u_mst.rd_byte(1'b0, b);
        u_mst.stop();
        `CHK("current address read", 8'h44, b)
        rd_seq(8'h0E, 2);
        `CHK("row start bytes", 16'h1122, {q[0], q[1]})
        // second reset in mid-run restores defaults
        @(posedge ref_clk);
        #1 rstn = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge ref_clk);
        `CHK("reset pulldowns", 9'h000, io_oe)
        `CHK("reset pullups", 9'h000, io_pu_en)
        rd_seq(8'hF0, 5);
        `CHK("reset regs", 40'h0000FF0100, {q[0], q[1], q[2], q[3], q[4]})
        rd_seq(8'h00, 1);
        `CHK("reset user byte", 8'h00, q[0])
        @(posedge ref_clk);
        #1 io_in = 9'h05A;
        repeat (4) @(posedge ref_clk);
        rd_seq(8'hF8, 2);
        `CHK("new pin levels", 16'h5A00, {q[0], q[1] & 8'h01})
        `CHK("sda open drain", 1'b0, sda_out)
        `CHK("pin outputs low", 9'h000, io_out)
        complete_run();
    end
endmodule // nvx_expander_tb
